// *** brktrg_pkg.sv ***
// Package for the breakpoint trigger unit: register map, field layout, codes and carriers
package brktrg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_PC_MATCH_VALUE    = 8'h00;
    localparam logic [7:0] OFF_PC_MATCH_IGNORE   = 8'h04;
    localparam logic [7:0] OFF_TRIGGER_SETUP     = 8'h08;
    localparam logic [7:0] OFF_ADDR_MATCH_LOW    = 8'h0C;
    localparam logic [7:0] OFF_ADDR_MATCH_HIGH   = 8'h10;
    localparam logic [7:0] OFF_DATA_MATCH_VALUE  = 8'h14;
    localparam logic [7:0] OFF_DATA_MATCH_IGNORE = 8'h18;
    localparam logic [7:0] OFF_DEBUG_STATUS      = 8'h1C;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_ONES = 32'hFFFF_FFFF;

    // Field positions within one 16-bit level half of trigger_setup
    localparam int LVL_ARM       = 13;
    localparam int LVL_FULL_BUS  = 12;
    localparam int LVL_LOW_HALF  = 11;
    localparam int LVL_HIGH_HALF = 10;
    localparam int LVL_BYTE0     = 9;
    localparam int LVL_BYTE1     = 8;
    localparam int LVL_BYTE2     = 7;
    localparam int LVL_BYTE3     = 6;
    localparam int LVL_DATA_INV  = 5;
    localparam int LVL_ADDR_OUT  = 4;
    localparam int LVL_ADDR_IN   = 3;
    localparam int LVL_ADDR_LOW  = 2;
    localparam int LVL_PC_EN     = 1;
    localparam int LVL_PC_INV    = 0;
    // Whole-register positions
    localparam int SETUP_OR_L2   = 15;
    localparam int SETUP_OR_L1   = 14;
    localparam int SETUP_ACT_HI  = 31;
    localparam int SETUP_ACT_LO  = 30;

    // Completed-trigger action codes
    localparam logic [1:0] ACT_TRACE = 2'h0;
    localparam logic [1:0] ACT_HALT  = 2'h1;
    localparam logic [1:0] ACT_IRQ   = 2'h2;

    // Trace codes shown on trace_data_outputs for one cycle
    localparam logic [3:0] TRACE_IDLE  = 4'h0;
    localparam logic [3:0] TRACE_LVL1  = 4'h1;
    localparam logic [3:0] TRACE_FINAL = 4'h2;

    // Access size encoding on the local bus
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_ARM_FIRST, ST_ARM_SECOND, ST_DONE} brktrg_state_e;

    // Executed instruction sample
    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
    } brktrg_pc_s;

    // Local bus cycle sample
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic [1:0]  size;
    } brktrg_bus_s;
endpackage

// *** brktrg_unit.sv ***
// Breakpoint trigger unit with AXI4-Lite register access
// Notes on behaviour
// R1: Hold 32-bit PC match value, compare PC
// R2: Set ignore bit drops that PC bit
// R3: Upper half second level, lower first
// R4: Setup write clears trigger state field
// R5: Action code: trace, halt, interrupt, reserved
// R6: Every completed trigger shows on trace outputs
// R7: Bit 15 picks AND or OR, level two
// R8: Bit 14 picks AND or OR, level one
// R9: Arm bit per level enables its trigger
// R10: Software disarms levels before loading registers
// R11: Full, low half, high half data lanes
// R12: Four byte lanes each select one byte
// R13: Data invert flips all data comparators
// R14: Outside-range address enable uses bounds exclusively
// R15: Inside-range enable uses inclusive bounds
// R16: Low-equal enable; none set disables address
// R17: PC condition only while PC enabled
// R18: PC invert selects outside masked region
// R19: Data ignore bits drop data compare bits
// R20: Operand lane follows address bits, size
// R21: Level two waits for level one only if level one is armed; act last
// R22: Conditions sampled per clock from core
module brktrg_unit (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // AXI4-Lite write address and data
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // AXI4-Lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [7:0]           s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    // Processor core samples
    input  wire brktrg_pkg::brktrg_pc_s  coreInstr,
    input  wire brktrg_pkg::brktrg_bus_s coreBus,
    // Responses to the core and trace port
    output logic                      haltRequest,
    output logic                      debugInterrupt,
    output logic [3:0]                trace_data_outputs
);
    // Registers
    logic [31:0]               pc_match_value;
    logic [31:0]               pc_match_ignore;
    logic [31:0]               trigger_setup;
    logic [31:0]               addr_match_low;
    logic [31:0]               addr_match_high;
    logic [31:0]               data_match_value;
    logic [31:0]               data_match_ignore;
    brktrg_pkg::brktrg_state_e trgState;
    brktrg_pkg::brktrg_state_e next_trgState;

    // Write channel holding
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;

    // Byte-enable merge, used by every writable register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= brktrg_pkg::OFF_DEBUG_STATUS);
    endfunction

    // One level: PC condition against address/data group, AND or OR combine
    function automatic logic level_fire(input logic [15:0] c, input logic orSel,
                                        input logic pcIn, input logic pcInside,
                                        input logic busIn, input logic eqLow,
                                        input logic inRange, input logic [3:0] laneEq,
                                        input logic [1:0] sz, input logic [1:0] a);
        logic pcEn;
        logic pcC;
        logic aEn;
        logic aC;
        logic dEn;
        logic dC;
        logic di;
        logic grp;
        logic andHit;
        pcEn = c[brktrg_pkg::LVL_PC_EN];                                   // see R17
        pcC  = pcIn & (pcInside ^ c[brktrg_pkg::LVL_PC_INV]);              // see R18
        aEn  = |c[brktrg_pkg::LVL_ADDR_OUT:brktrg_pkg::LVL_ADDR_LOW];      // see R16
        aC   = busIn & ((c[brktrg_pkg::LVL_ADDR_LOW] & eqLow)              // see R16
             | (c[brktrg_pkg::LVL_ADDR_IN] & inRange)                      // see R15
             | (c[brktrg_pkg::LVL_ADDR_OUT] & ~inRange));                  // see R14
        di   = c[brktrg_pkg::LVL_DATA_INV];                                // see R13
        dEn  = |c[brktrg_pkg::LVL_FULL_BUS:brktrg_pkg::LVL_BYTE3];          // see R11
        dC   = busIn & (
               (c[brktrg_pkg::LVL_FULL_BUS] & (sz == brktrg_pkg::SIZE_LONG)
                    & ((&laneEq) ^ di))                                    // see R11
             | (c[brktrg_pkg::LVL_HIGH_HALF] & (sz == brktrg_pkg::SIZE_WORD) & ~a[1]
                    & ((&laneEq[3:2]) ^ di))                               // see R20
             | (c[brktrg_pkg::LVL_LOW_HALF] & (sz == brktrg_pkg::SIZE_WORD) & a[1]
                    & ((&laneEq[1:0]) ^ di))                               // see R20
             | (c[brktrg_pkg::LVL_BYTE3] & (sz == brktrg_pkg::SIZE_BYTE) & (a == 2'h0)
                    & (laneEq[3] ^ di))                                    // see R12
             | (c[brktrg_pkg::LVL_BYTE2] & (sz == brktrg_pkg::SIZE_BYTE) & (a == 2'h1)
                    & (laneEq[2] ^ di))                                    // see R12
             | (c[brktrg_pkg::LVL_BYTE1] & (sz == brktrg_pkg::SIZE_BYTE) & (a == 2'h2)
                    & (laneEq[1] ^ di))                                    // see R12
             | (c[brktrg_pkg::LVL_BYTE0] & (sz == brktrg_pkg::SIZE_BYTE) & (a == 2'h3)
                    & (laneEq[0] ^ di)));                                  // see R12
        // Disabled parts count as satisfied, but something must be enabled
        grp    = (aEn | dEn) & (~aEn | aC) & (~dEn | dC);
        andHit = (pcEn | aEn | dEn) & (~pcEn | pcC) & (~aEn | aC) & (~dEn | dC);
        return c[brktrg_pkg::LVL_ARM] & (orSel ? ((pcEn & pcC) | grp) : andHit); // see R9
    endfunction

    // Shared comparators
    wire logic        pcInside = ~|((coreInstr.pc ^ pc_match_value) & ~pc_match_ignore); // see R1, R2
    wire logic [31:0] dataDiff = (coreBus.data ^ data_match_value) & ~data_match_ignore;  // see R19
    wire logic [3:0]  laneEq   = {~|dataDiff[31:24], ~|dataDiff[23:16],
                                  ~|dataDiff[15:8], ~|dataDiff[7:0]};
    wire logic        eqLow    = coreBus.addr == addr_match_low;
    wire logic        inRange  = (coreBus.addr >= addr_match_low)
                               && (coreBus.addr <= addr_match_high);               // see R15

    wire logic [15:0] cfgSecond = trigger_setup[31:16];                            // see R3
    wire logic [15:0] cfgFirst  = trigger_setup[15:0];                             // see R3
    wire logic [1:0]  action    = trigger_setup[brktrg_pkg::SETUP_ACT_HI:brktrg_pkg::SETUP_ACT_LO];
    wire logic        armFirst  = cfgFirst[brktrg_pkg::LVL_ARM];
    wire logic        armSecond = cfgSecond[brktrg_pkg::LVL_ARM];

    // Sampled each clock from whatever the core presents
    wire logic fireFirst = level_fire(cfgFirst, trigger_setup[brktrg_pkg::SETUP_OR_L1],
                                      coreInstr.valid, pcInside, coreBus.valid, eqLow,
                                      inRange, laneEq, coreBus.size,
                                      coreBus.addr[1:0]);                          // see R8, R22
    wire logic fireSecond = level_fire(cfgSecond, trigger_setup[brktrg_pkg::SETUP_OR_L2],
                                       coreInstr.valid, pcInside, coreBus.valid, eqLow,
                                       inRange, laneEq, coreBus.size,
                                       coreBus.addr[1:0]);                         // see R7, R22

    // Register writes
    wire logic doWrite    = awHeld & wHeld & ~s_axi_bvalid;
    wire logic setupWrite = doWrite && (awAddr == brktrg_pkg::OFF_TRIGGER_SETUP);

    // Trigger sequencing
    logic stepFirst;
    logic complete;
    always_comb begin
        next_trgState = trgState;
        stepFirst     = 1'b0;
        complete      = 1'b0;
        unique case (trgState)
            brktrg_pkg::ST_ARM_FIRST: begin
                if (armFirst && fireFirst) begin
                    stepFirst = armSecond;                                 // see R21
                    complete  = ~armSecond;
                    next_trgState = armSecond ? brktrg_pkg::ST_ARM_SECOND
                                              : brktrg_pkg::ST_DONE;
                end else if (!armFirst && armSecond && fireSecond) begin
                    complete      = 1'b1;
                    next_trgState = brktrg_pkg::ST_DONE;
                end
            end
            brktrg_pkg::ST_ARM_SECOND: begin
                if (fireSecond) begin                                      // see R21
                    complete      = 1'b1;
                    next_trgState = brktrg_pkg::ST_DONE;
                end
            end
            brktrg_pkg::ST_DONE: begin
                next_trgState = brktrg_pkg::ST_DONE;
            end
        endcase
        if (setupWrite) begin
            // Fresh configuration always restarts, and wins over any firing
            next_trgState = brktrg_pkg::ST_ARM_FIRST;                      // see R4
            stepFirst     = 1'b0;
            complete      = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            trgState           <= brktrg_pkg::ST_ARM_FIRST;
            haltRequest        <= 1'b0;
            debugInterrupt     <= 1'b0;
            trace_data_outputs <= brktrg_pkg::TRACE_IDLE;
        end else begin
            trgState           <= next_trgState;
            haltRequest        <= complete && (action == brktrg_pkg::ACT_HALT);     // see R5
            debugInterrupt     <= complete && (action == brktrg_pkg::ACT_IRQ);      // see R5
            trace_data_outputs <= complete  ? brktrg_pkg::TRACE_FINAL               // see R6
                                : stepFirst ? brktrg_pkg::TRACE_LVL1
                                            : brktrg_pkg::TRACE_IDLE;
        end
    end

    // Write path: address and data taken in either order, answered after both
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 8'h00;
            wData         <= brktrg_pkg::RST_ZERO;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= brktrg_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= ~awHeld & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~wHeld & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (mapped(awAddr) && awAddr != brktrg_pkg::OFF_DEBUG_STATUS)
                              ? brktrg_pkg::RESP_OKAY : brktrg_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register storage; software should disarm both levels while loading
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pc_match_value    <= brktrg_pkg::RST_ZERO;
            pc_match_ignore   <= brktrg_pkg::RST_ONES;
            trigger_setup     <= brktrg_pkg::RST_ZERO;
            addr_match_low    <= brktrg_pkg::RST_ZERO;
            addr_match_high   <= brktrg_pkg::RST_ZERO;
            data_match_value  <= brktrg_pkg::RST_ZERO;
            data_match_ignore <= brktrg_pkg::RST_ONES;
        end else if (doWrite) begin
            unique case (awAddr)
                brktrg_pkg::OFF_PC_MATCH_VALUE:
                    pc_match_value <= merge(pc_match_value, wData, wStrb);
                brktrg_pkg::OFF_PC_MATCH_IGNORE:
                    pc_match_ignore <= merge(pc_match_ignore, wData, wStrb);
                brktrg_pkg::OFF_TRIGGER_SETUP:
                    trigger_setup <= merge(trigger_setup, wData, wStrb);
                brktrg_pkg::OFF_ADDR_MATCH_LOW:
                    addr_match_low <= merge(addr_match_low, wData, wStrb);
                brktrg_pkg::OFF_ADDR_MATCH_HIGH:
                    addr_match_high <= merge(addr_match_high, wData, wStrb);
                brktrg_pkg::OFF_DATA_MATCH_VALUE:
                    data_match_value <= merge(data_match_value, wData, wStrb);
                brktrg_pkg::OFF_DATA_MATCH_IGNORE:
                    data_match_ignore <= merge(data_match_ignore, wData, wStrb);
                default: begin
                end
            endcase
        end
    end

    // Read path
    logic [31:0] readMux;
    always_comb begin
        unique case (s_axi_araddr)
            brktrg_pkg::OFF_PC_MATCH_VALUE:    readMux = pc_match_value;
            brktrg_pkg::OFF_PC_MATCH_IGNORE:   readMux = pc_match_ignore;
            brktrg_pkg::OFF_TRIGGER_SETUP:     readMux = trigger_setup;
            brktrg_pkg::OFF_ADDR_MATCH_LOW:    readMux = addr_match_low;
            brktrg_pkg::OFF_ADDR_MATCH_HIGH:   readMux = addr_match_high;
            brktrg_pkg::OFF_DATA_MATCH_VALUE:  readMux = data_match_value;
            brktrg_pkg::OFF_DATA_MATCH_IGNORE: readMux = data_match_ignore;
            brktrg_pkg::OFF_DEBUG_STATUS:      readMux = {30'h0000_0000, trgState};
            default:                           readMux = brktrg_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= brktrg_pkg::RST_ZERO;
            s_axi_rresp   <= brktrg_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= readMux;
                s_axi_rresp  <= mapped(s_axi_araddr) ? brktrg_pkg::RESP_OKAY
                                                     : brktrg_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    setup_clears_state_a: assert property (@(posedge clk_sys) disable iff (!nrst) // see R4
        setupWrite |=> trgState == brktrg_pkg::ST_ARM_FIRST)
        else $error("state not cleared by setup write");
    halt_action_a: assert property (@(posedge clk_sys) disable iff (!nrst) // see R5
        haltRequest |-> $past(action) == brktrg_pkg::ACT_HALT && trgState == brktrg_pkg::ST_DONE)
        else $error("halt without halt action");
    irq_action_a: assert property (@(posedge clk_sys) disable iff (!nrst) // see R5
        debugInterrupt |-> $past(action) == brktrg_pkg::ACT_IRQ && !haltRequest)
        else $error("interrupt without interrupt action");
    trace_on_done_a: assert property (@(posedge clk_sys) disable iff (!nrst) // see R6
        $changed(trgState) && trgState == brktrg_pkg::ST_DONE
            |-> trace_data_outputs == brktrg_pkg::TRACE_FINAL)
        else $error("completion not traced");
    disarmed_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst) // see R9
        !armFirst && !armSecond && !setupWrite |=> trace_data_outputs == brktrg_pkg::TRACE_IDLE)
        else $error("trigger while disarmed");
    second_after_first_a: assert property (@(posedge clk_sys) disable iff (!nrst) // see R21
        $rose(trgState == brktrg_pkg::ST_ARM_SECOND) |-> trace_data_outputs == brktrg_pkg::TRACE_LVL1)
        else $error("second level entered without first");
    pc_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst) // see R17
        !coreInstr.valid && !coreBus.valid |-> !fireFirst && !fireSecond)
        else $error("fire without sampled cycle");
    write_answer_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered");
    read_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
endmodule

// *** brktrg_core_model.sv ***
// Processor core model feeding executed-instruction and bus samples
module brktrg_core_model (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    // Step request from the bench
    input  wire logic               stepReq,
    input  wire logic [31:0]        stepPc,
    input  wire brktrg_pkg::brktrg_bus_s busStep,
    // Samples to the trigger unit
    output brktrg_pkg::brktrg_pc_s  coreInstr,
    output brktrg_pkg::brktrg_bus_s coreBus
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle fields keep toggling so a stale value can never pass for a match
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            coreInstr <= {1'b0, 32'h5A5A_5A5A};
            coreBus   <= {1'b0, 32'h5A5A_5A5A, 32'hA5A5_A5A5, 2'h2};
        end else begin
            coreInstr <= {stepReq, stepReq ? stepPc : ~coreInstr.pc};
            coreBus   <= (stepReq && busStep.valid) ? busStep
                                                    : {1'b0, ~coreBus.addr, ~coreBus.data, 2'h2};
        end
    end
endmodule

// *** brktrg_unit_test.sv ***
// Self-checking bench for the breakpoint trigger unit
module brktrg_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] A_SET  = brktrg_pkg::OFF_TRIGGER_SETUP;
    localparam logic [7:0] A_STAT = brktrg_pkg::OFF_DEBUG_STATUS;
    localparam logic [1:0] OK     = brktrg_pkg::RESP_OKAY;
    localparam logic [1:0] SZ_L   = brktrg_pkg::SIZE_LONG;
    localparam logic [1:0] SZ_B   = brktrg_pkg::SIZE_BYTE;
    logic                    clk_sys, nrst, awv, wv, bready, arv, rready, stepReq;
    logic                    awready, wready, bvalid, arready, rvalid, haltReq, dbgIrq;
    logic [7:0]              awaddr, araddr;
    logic [31:0]             wdata, rdata, stepPc;
    logic [1:0]              bresp, rresp;
    logic [3:0]              trace;
    brktrg_pkg::brktrg_pc_s  coreInstr;
    brktrg_pkg::brktrg_bus_s coreBus;
    brktrg_pkg::brktrg_bus_s busStep;
    int                      n_errors, comparisons;

    brktrg_unit brktrg_unit_inst (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .coreInstr(coreInstr), .coreBus(coreBus),
        .haltRequest(haltReq), .debugInterrupt(dbgIrq), .trace_data_outputs(trace));
    brktrg_core_model brktrg_core_model_inst (.clk_sys(clk_sys), .nrst(nrst),
        .stepReq(stepReq), .stepPc(stepPc), .busStep(busStep), .coreInstr(coreInstr),
        .coreBus(coreBus));

    task automatic stop_test;
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Handshakes are judged at the negedge before the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clk_sys);
        awv <= 1'b1;
        awaddr <= a;
        wv <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk_sys);
            ta = awv && awready;
            tw = wv && wready;
            tb = bvalid && bready;
            r = bresp;
            @(posedge clk_sys);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ta, tb;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk_sys);
        arv <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge clk_sys);
            ta = arv && arready;
            tb = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (ta) arv <= 1'b0;
        end
        rready <= 1'b0;
        chk(d, exp);
        chk({30'h0, r}, {30'h0, er});
    endtask
    // One instruction; the response must appear in the second cycle only, for one cycle
    task automatic fire(input logic [31:0] pc, input logic h, input logic i, input logic [3:0] t);
        logic [17:0] got;
        got = 18'h0;
        @(posedge clk_sys);
        stepReq <= 1'b1;
        stepPc <= pc;
        @(posedge clk_sys);
        stepReq <= 1'b0;
        repeat (3) begin
            @(negedge clk_sys);
            got = {got[11:0], haltReq, dbgIrq, trace};
        end
        chk({14'h0, got}, {20'h0, h, i, t, 6'h0});
    endtask
    // One bus cycle beside an instruction; PC condition is left disabled by the caller
    task automatic bus_fire(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s,
                            input logic [3:0] t);
        @(posedge clk_sys);
        busStep <= {1'b1, a, d, s};
        fire(32'h0, 1'b0, 1'b0, t);
        @(posedge clk_sys);
        busStep <= '0;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #100us;
        n_errors++;
        stop_test;
    end
    initial begin
        {nrst, awv, wv, bready, arv, rready, stepReq} = '0;
        {awaddr, araddr, wdata, stepPc} = '0;
        busStep = '0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(brktrg_pkg::OFF_PC_MATCH_IGNORE, 32'hFFFF_FFFF, OK);
        rd(8'h20, 32'h0, brktrg_pkg::RESP_SLVERR);
        wr(A_STAT, 32'h1, brktrg_pkg::RESP_SLVERR);
        wr(A_SET, 32'h0, OK);
        wr(brktrg_pkg::OFF_PC_MATCH_VALUE, 32'h0000_1230, OK);
        wr(brktrg_pkg::OFF_PC_MATCH_IGNORE, 32'h0000_000F, OK);
        for (int c = 0; c < 3; c++) begin
            wr(A_SET, {c[1:0], 30'h0000_2002}, OK);
            fire(32'h0000_1240, 1'b0, 1'b0, brktrg_pkg::TRACE_IDLE);
            fire(32'h0000_1237, c == 1, c == 2, brktrg_pkg::TRACE_FINAL);
        end
        rd(A_STAT, 32'h2, OK);
        fire(32'h0000_1237, 1'b0, 1'b0, brktrg_pkg::TRACE_IDLE);
        wr(A_SET, 32'h0000_2003, OK);
        rd(A_STAT, 32'h0, OK);
        fire(32'h0000_1237, 1'b0, 1'b0, brktrg_pkg::TRACE_IDLE);
        fire(32'h0000_1240, 1'b0, 1'b0, brktrg_pkg::TRACE_FINAL);
        wr(A_SET, 32'h0000_2000, OK);
        fire(32'h0000_1237, 1'b0, 1'b0, brktrg_pkg::TRACE_IDLE);
        wr(A_SET, 32'h0000_0002, OK);
        fire(32'h0000_1237, 1'b0, 1'b0, brktrg_pkg::TRACE_IDLE);
        wr(A_SET, 32'h6002_2002, OK);
        fire(32'h0000_1237, 1'b0, 1'b0, brktrg_pkg::TRACE_LVL1);
        rd(A_STAT, 32'h1, OK);
        fire(32'h0000_1237, 1'b1, 1'b0, brktrg_pkg::TRACE_FINAL);
        wr(A_SET, 32'h0, OK);
        wr(brktrg_pkg::OFF_ADDR_MATCH_LOW, 32'h0000_0100, OK);
        wr(brktrg_pkg::OFF_ADDR_MATCH_HIGH, 32'h0000_01FF, OK);
        wr(brktrg_pkg::OFF_DATA_MATCH_VALUE, 32'h1234_5678, OK);
        wr(brktrg_pkg::OFF_DATA_MATCH_IGNORE, 32'h0, OK);
        wr(A_SET, 32'h0000_3008, OK);
        bus_fire(32'h0000_0200, 32'h1234_5678, SZ_L, brktrg_pkg::TRACE_IDLE);
        bus_fire(32'h0000_0150, 32'h1234_5679, SZ_L, brktrg_pkg::TRACE_IDLE);
        bus_fire(32'h0000_0150, 32'h1234_5678, SZ_L, brktrg_pkg::TRACE_FINAL);
        wr(A_SET, 32'h0000_2210, OK);
        bus_fire(32'h0000_0103, 32'h0000_0078, SZ_B, brktrg_pkg::TRACE_IDLE);
        bus_fire(32'h0000_0203, 32'h0000_0078, SZ_B, brktrg_pkg::TRACE_FINAL);
        stop_test;
    end
endmodule
